// file: rtl/qec_counter.sv
// quadrature encoder counter with index capture and deviation watch
`default_nettype none
// Overview of operation
// - encoder inert while pulse-direction mode active
// - signed 32-bit position, readable and writable
// - constant is 16.16 signed, resets to 65536
// - each count adds or subtracts the constant
// - config bit 10 selects decimal fraction units
// - flags index bit0, deviation bit1, write-one clears
// - deviation clear ignored while deviation persists
// - both flags ORed onto interrupt output
// - index event copies position into capture
// - 20-bit limit sets warning; zero disables
// - config bit 9 also captures ramp position
// - config bit 8 clears position after capture
// - bits 7:6 choose level or edge sensitivity
// - bit 5 captures on first event after write
// - bit 4 captures on every index event
// - bit 3 clear requires A/B polarity match
// - bit 2 sets active index level
// - bits 0,1 give required A and B levels
module qec_counter (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // encoder pins
  input wire logic ENC_A_I,
  input wire logic ENC_B_I,
  input wire logic ENC_N_I,
  // device mode and ramp generator
  input wire logic STEP_DIR_MODE_I,
  input wire logic [31:0] RAMP_POS_I,
  // register port
  input wire logic [qec_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  // results
  output logic [31:0] RAMP_CAPTURE_O,
  output logic CAPTURE_O,
  output logic INT_O
);
  import qec_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [31:0] pos;
    logic [15:0] frac;
    logic [31:0] kconst;
    logic [FLAG_W-1:0] flags;
    logic [31:0] capture;
    logic [31:0] ramp_cap;
    logic [LIMIT_W-1:0] limit;
    logic a_prev;
    logic b_prev;
    logic match_prev;
    logic once_armed;
    logic cap_pulse;
    logic [31:0] rdata;
  } qec_state_s;

  qec_state_s st;
  qec_state_s next_st;

  logic [2:0] pins_sync;
  logic a_s;
  logic b_s;
  logic n_s;
  logic active;
  logic count_en;
  logic count_up;
  logic [16:0] frac_mod;
  logic [16:0] fsum;
  logic [16:0] fdif;
  logic carry;
  logic borrow;
  logic [31:0] k_int;
  logic [31:0] pos_count;
  logic [15:0] frac_count;
  logic n_active;
  logic match;
  logic qualify;
  logic take;
  logic [32:0] diff;
  logic [32:0] diff_abs;
  logic dev_cond;
  logic wr_cfg;
  logic wr_pos;
  logic wr_flags;

  // input synchroniser
  qec_sync #(
    .W(3)
  ) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .d_i({ENC_N_I, ENC_B_I, ENC_A_I}),
    .q_o(pins_sync)
  );

  assign a_s = pins_sync[0];
  assign b_s = pins_sync[1];
  assign n_s = pins_sync[2];

  always_comb begin
    next_st = st;
    wr_cfg = REG_WR_I && (REG_ADDR_I == ADDR_CONFIG);
    wr_pos = REG_WR_I && (REG_ADDR_I == ADDR_POSITION);
    wr_flags = REG_WR_I && (REG_ADDR_I == ADDR_FLAGS);
    // pins are reassigned in pulse-direction mode
    active = !STEP_DIR_MODE_I;

    // exactly one channel moved; glitches that move both are dropped
    count_en = active && (((a_s ^ st.a_prev) ^ (b_s ^ st.b_prev)) == 1'b1);
    count_up = a_s ^ st.b_prev;

    // fraction wraps at 65536 or 10000
    frac_mod = st.cfg[CFG_DECIMAL] ? FRAC_MOD_DEC : FRAC_MOD_BIN;
    k_int = {{16{st.kconst[31]}}, st.kconst[31:16]};
    fsum = {1'b0, st.frac} + {1'b0, st.kconst[15:0]};
    fdif = {1'b0, st.frac} - {1'b0, st.kconst[15:0]};
    carry = (fsum >= frac_mod);
    borrow = fdif[16];
    if (count_up) begin
      frac_count = carry ? 16'(fsum - frac_mod) : fsum[15:0];
      pos_count = st.pos + k_int + {31'h0000_0000, carry};
    end else begin
      frac_count = borrow ? 16'(fdif + frac_mod) : fdif[15:0];
      pos_count = st.pos - k_int - {31'h0000_0000, borrow};
    end

    // index qualification
    n_active = (n_s == st.cfg[CFG_POL_N]);
    match = active && n_active && (st.cfg[CFG_SKIP_AB] ||
            ((a_s == st.cfg[CFG_POL_A]) && (b_s == st.cfg[CFG_POL_B])));
    case ({st.cfg[CFG_NEG_EDGE], st.cfg[CFG_POS_EDGE]})
      2'b00: qualify = match;
      2'b01: qualify = match && !st.match_prev;
      2'b10: qualify = !match && st.match_prev;
      2'b11: qualify = match ^ st.match_prev;
      default: qualify = 1'b0;
    endcase
    // a mode change must not leave a stale edge behind
    qualify = qualify && active;
    take = qualify && (st.cfg[CFG_CLR_CONT] || st.once_armed);

    next_st.a_prev = a_s;
    next_st.b_prev = b_s;
    next_st.match_prev = match;
    next_st.cap_pulse = take;

    // counting, index clear, then software write in rising priority
    if (count_en) begin
      next_st.pos = pos_count;
      next_st.frac = frac_count;
    end
    if (take) begin
      next_st.capture = st.pos;
      if (st.cfg[CFG_CAP_RAMP]) begin
        next_st.ramp_cap = RAMP_POS_I;
      end
      if (st.cfg[CFG_CLR_POS]) begin
        next_st.pos = POS_RESET;
        next_st.frac = 16'h0000;
      end
      next_st.once_armed = 1'b0;
    end
    if (wr_pos) begin
      next_st.pos = REG_WDATA_I;
      next_st.frac = 16'h0000;
    end
    if (wr_cfg) begin
      next_st.cfg = REG_WDATA_I[CFG_W-1:0];
      next_st.once_armed = REG_WDATA_I[CFG_CLR_ONCE];
    end
    if (REG_WR_I && (REG_ADDR_I == ADDR_CONST)) begin
      next_st.kconst = REG_WDATA_I;
    end
    if (REG_WR_I && (REG_ADDR_I == ADDR_LIMIT)) begin
      next_st.limit = REG_WDATA_I[LIMIT_W-1:0];
    end

    // deviation watch on whole steps
    diff = {st.pos[31], st.pos} - {RAMP_POS_I[31], RAMP_POS_I};
    diff_abs = diff[32] ? 33'(-diff) : diff;
    dev_cond = (st.limit != LIMIT_RESET) &&
               (diff_abs > {13'h0000, st.limit});

    // write-one clear; a fresh event beats the clear
    if (wr_flags) begin
      next_st.flags = st.flags & ~REG_WDATA_I[FLAG_W-1:0];
    end
    if (qualify) begin
      next_st.flags[FLAG_INDEX] = 1'b1;
    end
    if (dev_cond) begin
      next_st.flags[FLAG_DEV] = 1'b1;
    end

    // read data held until the next read
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        ADDR_CONFIG: next_st.rdata = {21'h00_0000, st.cfg};
        ADDR_POSITION: next_st.rdata = st.pos;
        ADDR_FLAGS: next_st.rdata = {30'h0000_0000, st.flags};
        ADDR_CAPTURE: next_st.rdata = st.capture;
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      st <= '0;
      st.cfg <= CFG_RESET;
      st.pos <= POS_RESET;
      st.kconst <= CONST_RESET;
      st.limit <= LIMIT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign REG_RDATA_O = st.rdata;
  assign RAMP_CAPTURE_O = st.ramp_cap;
  assign CAPTURE_O = st.cap_pulse;
  assign INT_O = |st.flags;

  // pulse-direction mode freezes the counter unless software writes it
  chk_stepdir_frozen: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (STEP_DIR_MODE_I && !wr_pos) |=> (st.pos == $past(st.pos)))
    else $error("position moved in pulse-direction mode");

  chk_pos_write: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    wr_pos |=> (st.pos == $past(REG_WDATA_I)) && (st.frac == 16'h0000))
    else $error("written position not taken");

  chk_const_reset: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    $past(RST_I) |-> (st.kconst == CONST_RESET))
    else $error("constant not at reset value");

  chk_count_binary: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (count_en && count_up && !st.cfg[CFG_DECIMAL] && !take && !wr_pos) |=>
    ({st.pos, st.frac} == 48'($past({st.pos, st.frac}) +
      {{16{$past(st.kconst[31])}}, $past(st.kconst)})))
    else $error("binary up count wrong");

  chk_count_decimal: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (count_en && st.cfg[CFG_DECIMAL] && !take && !wr_pos && (st.kconst[15:0] < 16'h2710))
    |=> (st.frac < 16'h2710) || ($past(st.frac) >= 16'h2710))
    else $error("decimal fraction out of range");

  chk_dev_sticky: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (dev_cond && wr_flags && REG_WDATA_I[FLAG_DEV]) |=> st.flags[FLAG_DEV])
    else $error("deviation flag cleared while active");

  chk_irq_follows: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (qualify || dev_cond) |=> INT_O)
    else $error("interrupt missing after event");

  chk_capture_value: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    take |=> (st.capture == $past(st.pos)) && CAPTURE_O)
    else $error("capture holds wrong position");

  chk_limit_off: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    ((st.limit == LIMIT_RESET) && !st.flags[FLAG_DEV]) |=> !st.flags[FLAG_DEV])
    else $error("deviation set with check disabled");

  chk_ramp_capture: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (take && st.cfg[CFG_CAP_RAMP]) |=> (RAMP_CAPTURE_O == $past(RAMP_POS_I)))
    else $error("ramp position not captured");

  chk_index_clear: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (take && st.cfg[CFG_CLR_POS] && !wr_pos) |=> (st.pos == POS_RESET))
    else $error("position not cleared on index");

  chk_once_disarm: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (take && !st.cfg[CFG_CLR_CONT] && !wr_cfg) |=> !st.once_armed ##1 !take)
    else $error("single capture repeated");

  chk_edge_rise: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (({st.cfg[CFG_NEG_EDGE], st.cfg[CFG_POS_EDGE]} == 2'b01) && qualify) |->
    (match && !$past(match)))
    else $error("rising index edge misdetected");

  chk_stepdir_noindex: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    STEP_DIR_MODE_I |-> (!qualify && !take))
    else $error("index event in pulse-direction mode");

  chk_flag_clear: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (wr_flags && REG_WDATA_I[FLAG_INDEX] && !qualify) |=> !st.flags[FLAG_INDEX])
    else $error("index flag not cleared");

  chk_every_event: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (qualify && st.cfg[CFG_CLR_CONT]) |=> CAPTURE_O && (st.capture == $past(st.pos)))
    else $error("continuous capture missed");

  chk_index_level: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (st.cfg[CFG_SKIP_AB] && (n_s != st.cfg[CFG_POL_N])) |-> !match)
    else $error("inactive index level matched");
endmodule
`default_nettype wire

// file: rtl/qec_pkg.sv
// constants for the quadrature encoder counter
`default_nettype none
package qec_pkg;
  // register interface
  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0] ADDR_CONFIG = 7'h38;
  localparam logic [6:0] ADDR_POSITION = 7'h39;
  localparam logic [6:0] ADDR_CONST = 7'h3a;
  localparam logic [6:0] ADDR_FLAGS = 7'h3b;
  localparam logic [6:0] ADDR_CAPTURE = 7'h3c;
  localparam logic [6:0] ADDR_LIMIT = 7'h3d;
  // widths
  localparam int unsigned CFG_W = 11;
  localparam int unsigned LIMIT_W = 20;
  localparam int unsigned FLAG_W = 2;
  // encoder_config field positions
  localparam int unsigned CFG_POL_A = 0;
  localparam int unsigned CFG_POL_B = 1;
  localparam int unsigned CFG_POL_N = 2;
  localparam int unsigned CFG_SKIP_AB = 3;
  localparam int unsigned CFG_CLR_CONT = 4;
  localparam int unsigned CFG_CLR_ONCE = 5;
  localparam int unsigned CFG_POS_EDGE = 6;
  localparam int unsigned CFG_NEG_EDGE = 7;
  localparam int unsigned CFG_CLR_POS = 8;
  localparam int unsigned CFG_CAP_RAMP = 9;
  localparam int unsigned CFG_DECIMAL = 10;
  // encoder_flags field positions
  localparam int unsigned FLAG_INDEX = 0;
  localparam int unsigned FLAG_DEV = 1;
  // reset values
  localparam logic [10:0] CFG_RESET = 11'h000;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  localparam logic [31:0] CONST_RESET = 32'h0001_0000;
  localparam logic [19:0] LIMIT_RESET = 20'h0_0000;
  // fraction moduli: binary and decimal
  localparam logic [16:0] FRAC_MOD_BIN = 17'h1_0000;
  localparam logic [16:0] FRAC_MOD_DEC = 17'h0_2710;
  // synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
endpackage
`default_nettype wire

// file: rtl/qec_sync.sv
// two-flop synchroniser for the encoder inputs
`default_nettype none
module qec_sync #(
  parameter int unsigned W = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  import qec_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } qec_sync_s;

  qec_sync_s st;
  qec_sync_s next_st;

  // first stage feeds only the second
  always_comb begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;
endmodule
`default_nettype wire

// file: test/qec_enc_model.sv
// incremental quadrature encoder model with index channel
`default_nettype none
module qec_enc_model (
  input wire logic clk_i,
  output logic a_o,
  output logic b_o,
  output logic n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  initial n_o = 1'b0;
  // gray order 00,10,11,01: one channel per step
  assign a_o = ph[0] ^ ph[1];
  assign b_o = ph[1];
  task automatic step(input bit up);
    @(posedge clk_i);
    #1;
    ph = up ? ph + 2'h1 : ph - 2'h1; // ninety-degree offset
    repeat (3) @(posedge clk_i); // held well past sampling
  endtask
  task automatic pulse();
    @(posedge clk_i);
    #1;
    n_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    n_o = 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: test/qec_counter_tb.sv
// self-checking bench for the quadrature encoder counter
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t: got %h want %h", $time, g, e); end end
module qec_counter_tb;
  import qec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] ramp = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rcap;
  logic cap;
  logic irq;
  wire a;
  wire b;
  wire n;
  int err_count = 0;
  int n_compared = 0;
  int cap_count = 0;
  qec_enc_model enc (.clk_i(clk), .a_o(a), .b_o(b), .n_o(n));
  qec_counter uut (.SYS_CLK_I(clk), .RST_I(rst), .ENC_A_I(a), .ENC_B_I(b), .ENC_N_I(n),
    .STEP_DIR_MODE_I(mode), .RAMP_POS_I(ramp), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .RAMP_CAPTURE_O(rcap),
    .CAPTURE_O(cap), .INT_O(irq));
  initial forever #2 clk = ~clk;
  // pulse is one cycle wide, so count it mid-cycle
  always @(negedge clk) begin
    if (cap) begin
      cap_count++;
    end
  end
  task automatic wr_reg(input logic [6:0] ad, input logic [31:0] d);
    @(posedge clk);
    #1;
    addr = ad;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask
  task automatic chk_reg(input logic [6:0] ad, input logic [31:0] e);
    @(posedge clk);
    #1;
    addr = ad;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    `CHK(rdata, e)
  endtask
  task automatic steps(input int k, input bit up);
    repeat (k) enc.step(up);
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset();
    chk_reg(ADDR_CONFIG, 32'h0);
    chk_reg(ADDR_POSITION, 32'h0);
    // default is level mode, low-active index with A and B low: idle pins match
    chk_reg(ADDR_FLAGS, 32'h1);
    chk_reg(ADDR_CAPTURE, 32'h0);
    chk_reg(ADDR_CONST, 32'h0);
    chk_reg(7'h40, 32'h0);
    `CHK(irq, 1'b1)
  endtask
  task automatic t_count();
    steps(4, 1'b1);
    steps(2, 1'b0);
    chk_reg(ADDR_POSITION, 32'h2);
    wr_reg(ADDR_CONST, 32'h0002_8000);
    steps(2, 1'b1);
    chk_reg(ADDR_POSITION, 32'h7);
    wr_reg(ADDR_POSITION, 32'h0);
    wr_reg(ADDR_CONFIG, 32'h400);
    wr_reg(ADDR_CONST, 32'h0000_1388);
    steps(2, 1'b1);
    chk_reg(ADDR_POSITION, 32'h1);
    mode = 1'b1;
    steps(2, 1'b1);
    mode = 1'b0;
    chk_reg(ADDR_POSITION, 32'h1);
    wr_reg(ADDR_CONFIG, 32'h0);
    wr_reg(ADDR_CONST, CONST_RESET);
  endtask
  // rising index, every event, clear, ramp capture, A/B ignored
  task automatic t_index();
    int c0;
    ramp = 32'h0000_0123;
    wr_reg(ADDR_CONFIG, 32'h35c);
    wr_reg(ADDR_FLAGS, 32'h1);
    chk_reg(ADDR_FLAGS, 32'h0);
    wr_reg(ADDR_POSITION, 32'hffff_fff9);
    chk_reg(ADDR_POSITION, 32'hffff_fff9);
    c0 = cap_count;
    enc.pulse();
    `CHK(cap_count, c0 + 1)
    chk_reg(ADDR_CAPTURE, 32'hffff_fff9);
    chk_reg(ADDR_POSITION, 32'h0);
    `CHK(rcap, 32'h0000_0123)
    chk_reg(ADDR_FLAGS, 32'h1);
    `CHK(irq, 1'b1)
    wr_reg(ADDR_FLAGS, 32'h1);
    chk_reg(ADDR_FLAGS, 32'h0);
    wr_reg(ADDR_POSITION, 32'h5);
    enc.pulse();
    chk_reg(ADDR_CAPTURE, 32'h5);
  endtask
  // falling index, armed once, no clear
  task automatic t_once();
    int c0;
    ramp = 32'h0000_0456;
    wr_reg(ADDR_CONFIG, 32'h0ac);
    wr_reg(ADDR_POSITION, 32'h3);
    enc.pulse();
    chk_reg(ADDR_CAPTURE, 32'h3);
    chk_reg(ADDR_POSITION, 32'h3);
    `CHK(rcap, 32'h0000_0123)
    wr_reg(ADDR_POSITION, 32'h9);
    c0 = cap_count;
    enc.pulse();
    chk_reg(ADDR_CAPTURE, 32'h3);
    `CHK(cap_count, c0)
  endtask
  // low-active index in level mode captures while idle low
  task automatic t_level();
    wr_reg(ADDR_POSITION, 32'h4);
    wr_reg(ADDR_CONFIG, 32'h018);
    repeat (3) @(posedge clk);
    chk_reg(ADDR_CAPTURE, 32'h4);
  endtask
  // A and B must both be high for the event
  task automatic t_ab();
    wr_reg(ADDR_CONFIG, 32'h057);
    wr_reg(ADDR_POSITION, 32'h6);
    enc.pulse();
    chk_reg(ADDR_CAPTURE, 32'h4);
    steps(2, 1'b1);
    enc.pulse();
    chk_reg(ADDR_CAPTURE, 32'h8);
  endtask
  task automatic t_dev();
    wr_reg(ADDR_CONFIG, 32'h0);
    ramp = 32'h0;
    wr_reg(ADDR_LIMIT, 32'h2);
    wr_reg(ADDR_POSITION, 32'ha);
    wr_reg(ADDR_FLAGS, 32'h3);
    chk_reg(ADDR_FLAGS, 32'h2);
    `CHK(irq, 1'b1)
    wr_reg(ADDR_POSITION, 32'h2);
    wr_reg(ADDR_FLAGS, 32'h2);
    chk_reg(ADDR_FLAGS, 32'h0);
    wr_reg(ADDR_LIMIT, 32'h0);
    wr_reg(ADDR_POSITION, 32'ha);
    chk_reg(ADDR_FLAGS, 32'h0);
    `CHK(irq, 1'b0)
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_count();
    t_index();
    t_once();
    t_level();
    t_ab();
    t_dev();
    results();
  end
  // the whole run needs a few hundred cycles
  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
